// ==== inc/brpc_regs.svh ====
// register offsets, field positions, reset values and timing counts for the rtc power controller
// assumes a 32-bit word-addressed register port with byte offsets
// What this block does
// - low-battery enable set and battery low sets the low-battery raw flag.
// - abort enable plus low battery refuses sleep, regulator stays on.
// - battery not evaluated while hibernating.
// - 32-bit seconds counter advances once per predivider second.
// - predivider reloads 0x7FFF, uses trim value one second in 64.
// - trim above 0x7FFF slows counter, below speeds it.
// - two match registers compared; match wakes or raises event.
// - seconds counter advances only while counter enable set.
// - load register write replaces counter at any time.
// - counting continues regardless of main power or hibernation.
// - 64 retained 32-bit words accessible to software.
// - assert regulator-off low, hold until wake, then release.
// - wake on low wake pin or match when respective enable set.
// - three event sources: wake pin, counter match, low battery.
// - masked events ORed into one interrupt line.
// - raw status shows all pending; masked shows enabled pending.
// - mask selects interrupt events; write one to clear register clears.
// - control bit 2 selects oscillator input or crystal divided by 128.
// - clock enable bit persists across hibernation and is readable.
// - registers reset only by cold power-on or reset with counter and pin wake off.
// - control bit 7 is power-cut abort enable.
`ifndef BRPC_REGS_SVH
`define BRPC_REGS_SVH
`define BRPC_OFF_COUNT 12'h000
`define BRPC_OFF_MATCH0 12'h004
`define BRPC_OFF_MATCH1 12'h008
`define BRPC_OFF_LOAD 12'h00C
`define BRPC_OFF_CTL 12'h010
`define BRPC_OFF_MASK 12'h014
`define BRPC_OFF_RAW 12'h018
`define BRPC_OFF_MASKED 12'h01C
`define BRPC_OFF_CLEAR 12'h020
`define BRPC_OFF_TRIM 12'h024
`define BRPC_OFF_MEM_LO 12'h030
`define BRPC_OFF_MEM_HI 12'h12C
`define BRPC_CTL_SLEEP_REQ 0
`define BRPC_CTL_MATCH_WAKE 1
`define BRPC_CTL_CLK_SEL 2
`define BRPC_CTL_PIN_WAKE 4
`define BRPC_CTL_CNT_EN 5
`define BRPC_CTL_CLK_EN 6
`define BRPC_CTL_ABORT 7
`define BRPC_CTL_LOW_BATT_FLAG_EN 3
`define BRPC_CTL_RESET 32'h80000000
`define BRPC_CTL_RW_MASK 32'h000000FE
`define BRPC_MATCH_RESET 32'hFFFFFFFF
`define BRPC_LOAD_RESET 32'hFFFFFFFF
`define BRPC_TRIM_RESET 16'h7FFF
`define BRPC_PREDIV_NOMINAL 16'h7FFF
`define BRPC_TRIM_PERIOD 6'h3F
`define BRPC_XTAL_DIV 7'h7F
`define BRPC_EV_MATCH0 0
`define BRPC_EV_MATCH1 1
`define BRPC_EV_LOW_BATT_FLAG 2
`define BRPC_EV_PIN 3
`endif

// ==== inc/brpc_pkg.sv ====
// types for the rtc power controller
// assumes brpc_regs.svh supplies the numeric constants
package brpc_pkg;
	typedef enum logic [2:0] {
		BRPC_AWAKE = 3'b001,
		BRPC_ASLEEP = 3'b010,
		BRPC_WAKING = 3'b100
	} brpc_power_e;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} brpc_bus_s;
	typedef logic [3:0] brpc_events_t;
endpackage

// ==== logic/brpc_core.sv ====
// rtc seconds counter, retained memory, events and power sequencing
// assumes synchronous inputs on sys_clk; ref ticks arrive as a one-cycle pulse
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "brpc_regs.svh"
module brpc_core #(
	parameter int MEM_WORDS = 64
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// register port
	input wire brpc_pkg::brpc_bus_s bus,
	output logic [31:0] rdata,
	// reference ticks: crystal edge pulse and direct oscillator pulse
	input wire logic xtal_tick,
	input wire logic osc_tick,
	// battery and pins
	input wire logic batt_low,
	input wire logic wake_n,
	output logic regulator_off_n,
	output logic regulator_off_oe_n,
	output logic irq
);
	logic [31:0] count, next_count;
	logic [31:0] match0, next_match0, match1, next_match1, load, next_load;
	logic [31:0] ctl, next_ctl;
	logic [15:0] trim, next_trim, prediv, next_prediv;
	logic [5:0] sec_idx, next_sec_idx;
	logic [6:0] xdiv, next_xdiv;
	brpc_pkg::brpc_events_t raw, next_raw, mask, next_mask;
	brpc_pkg::brpc_power_e pstate, next_pstate;
	logic [31:0] mem [MEM_WORDS];
	logic [31:0] next_rdata;
	logic next_reg_off_n, next_irq;
	logic ref_tick, sec_tick, wr_ok, in_mem;
	logic m0_hit, m1_hit, low_batt_flag_ev, pin_ev, want_sleep, wake_ev;
	logic [5:0] mem_idx;
	logic [11:0] mem_off;
	logic [16:0] tick_run, next_tick_run;
	logic [15:0] sec_reload, next_sec_reload;
	logic [7:0] xt_gap, next_xt_gap;
	logic xt_armed, next_xt_armed;

	assign mem_off = bus.addr - `BRPC_OFF_MEM_LO;
	assign mem_idx = mem_off[7:2];
	assign in_mem = bus.addr >= `BRPC_OFF_MEM_LO && bus.addr <= `BRPC_OFF_MEM_HI && bus.addr[1:0] == 2'h0;
	assign wr_ok = bus.wr;

	always_comb begin
		next_xdiv = xdiv;
		if (xtal_tick)
			next_xdiv = xdiv + 7'h01;
		ref_tick = ctl[`BRPC_CTL_CLK_EN] && (ctl[`BRPC_CTL_CLK_SEL] ? osc_tick : (xtal_tick && xdiv == `BRPC_XTAL_DIV));
	end

	always_comb begin
		next_prediv = prediv;
		next_sec_idx = sec_idx;
		sec_tick = 1'b0;
		if (ref_tick && ctl[`BRPC_CTL_CNT_EN]) begin
			if (prediv == 16'h0000) begin
				sec_tick = 1'b1;
				next_sec_idx = sec_idx + 6'h01;
				next_prediv = (next_sec_idx == `BRPC_TRIM_PERIOD) ? trim : `BRPC_PREDIV_NOMINAL;
			end else begin
				next_prediv = prediv - 16'h0001;
			end
		end
	end

	always_comb begin
		next_count = count;
		if (sec_tick)
			next_count = count + 32'h00000001;
		if (wr_ok && bus.addr == `BRPC_OFF_LOAD)
			next_count = bus.wdata;
	end

	assign m0_hit = next_count == match0 && next_count != count;
	assign m1_hit = next_count == match1 && next_count != count;
	assign low_batt_flag_ev = ctl[`BRPC_CTL_LOW_BATT_FLAG_EN] && batt_low && pstate == brpc_pkg::BRPC_AWAKE;
	assign pin_ev = !wake_n;
	assign wake_ev = (ctl[`BRPC_CTL_PIN_WAKE] && pin_ev) || (ctl[`BRPC_CTL_MATCH_WAKE] && (m0_hit || m1_hit));
	assign want_sleep = ctl[`BRPC_CTL_SLEEP_REQ] && !(ctl[`BRPC_CTL_ABORT] && (raw[`BRPC_EV_LOW_BATT_FLAG] || low_batt_flag_ev));

	// registers: control, match, load, trim, mask, clear
	always_comb begin
		next_ctl = ctl;
		next_match0 = match0;
		next_match1 = match1;
		next_load = load;
		next_trim = trim;
		next_mask = mask;
		next_raw = raw;
		if (wr_ok) begin
			unique case (bus.addr)
				`BRPC_OFF_CTL: next_ctl = (bus.wdata & `BRPC_CTL_RW_MASK) | (32'(bus.wdata[`BRPC_CTL_SLEEP_REQ]));
				`BRPC_OFF_MATCH0: next_match0 = bus.wdata;
				`BRPC_OFF_MATCH1: next_match1 = bus.wdata;
				`BRPC_OFF_LOAD: next_load = bus.wdata;
				`BRPC_OFF_TRIM: next_trim = bus.wdata[15:0];
				`BRPC_OFF_MASK: next_mask = bus.wdata[3:0];
				`BRPC_OFF_CLEAR: next_raw = raw & ~bus.wdata[3:0];
				default: ;
			endcase
		end
		if (m0_hit)
			next_raw[`BRPC_EV_MATCH0] = 1'b1;
		if (m1_hit)
			next_raw[`BRPC_EV_MATCH1] = 1'b1;
		if (low_batt_flag_ev)
			next_raw[`BRPC_EV_LOW_BATT_FLAG] = 1'b1;
		if (pin_ev)
			next_raw[`BRPC_EV_PIN] = 1'b1;
		if (pstate == brpc_pkg::BRPC_AWAKE && ctl[`BRPC_CTL_SLEEP_REQ])
			next_ctl[`BRPC_CTL_SLEEP_REQ] = 1'b0;
		// clock enable always reads one once set
		next_ctl[31] = ctl[31];
		if (ctl[`BRPC_CTL_CLK_EN])
			next_ctl[`BRPC_CTL_CLK_EN] = 1'b1;
	end

	always_comb begin
		next_pstate = pstate;
		unique case (pstate)
			brpc_pkg::BRPC_AWAKE: if (want_sleep) next_pstate = brpc_pkg::BRPC_ASLEEP;
			brpc_pkg::BRPC_ASLEEP: if (wake_ev) next_pstate = brpc_pkg::BRPC_WAKING;
			brpc_pkg::BRPC_WAKING: next_pstate = brpc_pkg::BRPC_AWAKE;
			default: next_pstate = brpc_pkg::BRPC_AWAKE;
		endcase
		next_reg_off_n = next_pstate != brpc_pkg::BRPC_ASLEEP;
	end

	always_comb begin
		next_irq = |(next_raw & next_mask);
		next_rdata = 32'h00000000;
		if (bus.rd) begin
			if (in_mem) begin
				next_rdata = mem[mem_idx];
			end else begin
				unique case (bus.addr)
					`BRPC_OFF_COUNT: next_rdata = count;
					`BRPC_OFF_MATCH0: next_rdata = match0;
					`BRPC_OFF_MATCH1: next_rdata = match1;
					`BRPC_OFF_LOAD: next_rdata = load;
					`BRPC_OFF_CTL: next_rdata = ctl;
					`BRPC_OFF_MASK: next_rdata = {28'h0000000, mask};
					`BRPC_OFF_RAW: next_rdata = {28'h0000000, raw};
					`BRPC_OFF_MASKED: next_rdata = {28'h0000000, raw & mask};
					`BRPC_OFF_TRIM: next_rdata = {16'h0000, trim};
					default: next_rdata = 32'h00000000;
				endcase
			end
		end
	end

	// resetn is the qualified module reset built outside
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count <= 32'h00000000;
			match0 <= `BRPC_MATCH_RESET;
			match1 <= `BRPC_MATCH_RESET;
			load <= `BRPC_LOAD_RESET;
			ctl <= `BRPC_CTL_RESET;
			trim <= `BRPC_TRIM_RESET;
			prediv <= `BRPC_PREDIV_NOMINAL;
			sec_idx <= 6'h00;
			xdiv <= 7'h00;
			mask <= 4'h0;
			raw <= 4'h0;
			pstate <= brpc_pkg::BRPC_AWAKE;
			rdata <= 32'h00000000;
			regulator_off_n <= 1'b1;
			irq <= 1'b0;
		end else begin
			count <= next_count;
			match0 <= next_match0;
			match1 <= next_match1;
			load <= next_load;
			ctl <= next_ctl;
			trim <= next_trim;
			prediv <= next_prediv;
			sec_idx <= next_sec_idx;
			xdiv <= next_xdiv;
			mask <= next_mask;
			raw <= next_raw;
			pstate <= next_pstate;
			rdata <= next_rdata;
			regulator_off_n <= next_reg_off_n;
			irq <= next_irq;
		end
	end
	assign regulator_off_oe_n = regulator_off_n;

	always_ff @(posedge sys_clk) begin
		if (wr_ok && in_mem)
			mem[mem_idx] <= bus.wdata;
	end

	// checker bookkeeping: ticks per second, crystal edges per tick
	always_comb begin
		next_tick_run = tick_run;
		next_sec_reload = sec_reload;
		next_xt_gap = xt_gap;
		next_xt_armed = xt_armed;
		if (sec_tick) begin
			next_tick_run = 17'h00000;
			next_sec_reload = next_prediv;
		end else if (ref_tick && ctl[`BRPC_CTL_CNT_EN]) begin
			next_tick_run = tick_run + 17'h00001;
		end
		// gap restarts whenever the crystal path is off
		if (!ctl[`BRPC_CTL_CLK_EN] || ctl[`BRPC_CTL_CLK_SEL]) begin
			next_xt_gap = 8'h00;
			next_xt_armed = 1'b0;
		end else if (ref_tick) begin
			next_xt_gap = 8'h00;
			next_xt_armed = 1'b1;
		end else if (xtal_tick && xt_gap != 8'hFF) begin
			next_xt_gap = xt_gap + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tick_run <= 17'h00000;
			sec_reload <= `BRPC_PREDIV_NOMINAL;
			xt_gap <= 8'h00;
			xt_armed <= 1'b0;
		end else begin
			tick_run <= next_tick_run;
			sec_reload <= next_sec_reload;
			xt_gap <= next_xt_gap;
			xt_armed <= next_xt_armed;
		end
	end

	sequence s_sleep_taken;
		pstate == brpc_pkg::BRPC_AWAKE && want_sleep;
	endsequence
	sequence s_regulator_cut;
		pstate == brpc_pkg::BRPC_ASLEEP && !regulator_off_n;
	endsequence
	sequence s_wake_seen;
		pstate == brpc_pkg::BRPC_ASLEEP && wake_ev;
	endsequence
	sequence s_wake_return;
		pstate == brpc_pkg::BRPC_WAKING && regulator_off_n ##1 pstate == brpc_pkg::BRPC_AWAKE && regulator_off_n;
	endsequence

	a_load_replaces: assert property (@(posedge sys_clk) disable iff (!resetn)
		bus.wr && bus.addr == `BRPC_OFF_LOAD |=> count == $past(bus.wdata)) else $error("load not applied");

	a_count_gated: assert property (@(posedge sys_clk) disable iff (!resetn)
		!ctl[`BRPC_CTL_CNT_EN] && !(bus.wr && bus.addr == `BRPC_OFF_LOAD) |=> $stable(count))
		else $error("count moved");

	a_second_step: assert property (@(posedge sys_clk) disable iff (!resetn)
		sec_tick && !(bus.wr && bus.addr == `BRPC_OFF_LOAD) |=> count == $past(count) + 32'h00000001)
		else $error("second step wrong");

	a_count_asleep: assert property (@(posedge sys_clk) disable iff (!resetn)
		pstate != brpc_pkg::BRPC_AWAKE && sec_tick && !(bus.wr && bus.addr == `BRPC_OFF_LOAD)
		|=> count == $past(count) + 32'h00000001) else $error("count stopped asleep");

	a_nominal_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
		sec_tick && (sec_idx + 6'h01) != `BRPC_TRIM_PERIOD |=> prediv == `BRPC_PREDIV_NOMINAL)
		else $error("nominal reload missing");

	a_second_length: assert property (@(posedge sys_clk) disable iff (!resetn)
		sec_tick |-> tick_run == {1'b0, sec_reload}) else $error("second length wrong");

	a_xtal_ratio: assert property (@(posedge sys_clk) disable iff (!resetn)
		ctl[`BRPC_CTL_CLK_EN] && !ctl[`BRPC_CTL_CLK_SEL] && ref_tick && xt_armed |-> xt_gap == {1'b0, `BRPC_XTAL_DIV})
		else $error("crystal divide wrong");

	a_abort_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
		pstate == brpc_pkg::BRPC_AWAKE && ctl[`BRPC_CTL_ABORT] && raw[`BRPC_EV_LOW_BATT_FLAG] |=> regulator_off_n)
		else $error("sleep not aborted");

	a_abort_now: assert property (@(posedge sys_clk) disable iff (!resetn)
		pstate == brpc_pkg::BRPC_AWAKE && ctl[`BRPC_CTL_ABORT] && low_batt_flag_ev |=> regulator_off_n)
		else $error("abort ignored");

	a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_sleep_taken |=> s_regulator_cut) else $error("sleep entry wrong");

	a_sleep_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
		pstate == brpc_pkg::BRPC_ASLEEP && !wake_ev |=> !regulator_off_n) else $error("regulator released early");

	a_wake_release: assert property (@(posedge sys_clk) disable iff (!resetn)
		pstate == brpc_pkg::BRPC_ASLEEP && wake_ev |=> regulator_off_n) else $error("wake missed");

	a_wake_steps: assert property (@(posedge sys_clk) disable iff (!resetn)
		s_wake_seen |=> s_wake_return) else $error("wake steps wrong");

	a_irq_or: assert property (@(posedge sys_clk) disable iff (!resetn)
		irq == |($past(next_raw) & $past(next_mask)) || $rose(resetn)) else $error("irq mismatch");

	a_irq_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
		irq == |(raw & mask)) else $error("irq not masked status");

	a_low_batt_flag_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
		low_batt_flag_ev |=> raw[`BRPC_EV_LOW_BATT_FLAG]) else $error("low battery flag missing");

	a_no_low_batt_flag_asleep: assert property (@(posedge sys_clk) disable iff (!resetn)
		pstate == brpc_pkg::BRPC_ASLEEP && !raw[`BRPC_EV_LOW_BATT_FLAG] |=> !raw[`BRPC_EV_LOW_BATT_FLAG])
		else $error("battery judged asleep");

	a_match_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
		m0_hit |=> raw[`BRPC_EV_MATCH0]) else $error("match flag missing");

	a_match1_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
		m1_hit |=> raw[`BRPC_EV_MATCH1]) else $error("second match flag missing");

	a_pin_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
		!wake_n |=> raw[`BRPC_EV_PIN]) else $error("pin flag missing");

	a_clear_raw: assert property (@(posedge sys_clk) disable iff (!resetn)
		bus.wr && bus.addr == `BRPC_OFF_CLEAR && bus.wdata[`BRPC_EV_PIN] && wake_n |=> !raw[`BRPC_EV_PIN])
		else $error("clear failed");

	a_raw_read: assert property (@(posedge sys_clk) disable iff (!resetn)
		bus.rd && bus.addr == `BRPC_OFF_RAW |=> rdata == {28'h0000000, $past(raw)}) else $error("raw read wrong");

	a_masked_read: assert property (@(posedge sys_clk) disable iff (!resetn)
		bus.rd && bus.addr == `BRPC_OFF_MASKED |=> rdata == {28'h0000000, $past(raw & mask)})
		else $error("masked read wrong");

	a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
		!bus.rd |=> rdata == 32'h00000000) else $error("read data not idle");

	a_mem_write: assert property (@(posedge sys_clk) disable iff (!resetn)
		bus.wr && in_mem |=> mem[$past(mem_idx)] == $past(bus.wdata)) else $error("retained write lost");

	a_clk_sticky: assert property (@(posedge sys_clk) disable iff (!resetn)
		ctl[`BRPC_CTL_CLK_EN] |=> ctl[`BRPC_CTL_CLK_EN]) else $error("clock enable dropped");

	a_ctl_marker: assert property (@(posedge sys_clk) disable iff (!resetn)
		ctl[31]) else $error("control marker bit lost");
endmodule

// ==== sim/brpc_far_side.sv ====
// far side model: regulator enable wire, wake pin, battery sense and reference ticks
// assumes the bench steers battery and wake pin through the cmd inputs
`timescale 1ns/1ps
module brpc_far_side (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// bench controls
	input wire logic batt_cmd,
	input wire logic wake_cmd,
	// device pins
	input wire logic regulator_off_n,
	input wire logic regulator_off_oe_n,
	output logic xtal_tick,
	output logic osc_tick,
	output logic batt_low,
	output logic wake_n,
	output logic power_on
);
	assign power_on = regulator_off_oe_n | regulator_off_n;
	assign wake_n = !wake_cmd;
	assign batt_low = batt_cmd;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			osc_tick <= 1'b0;
			xtal_tick <= 1'b0;
		end else begin
			osc_tick <= 1'b1;
			xtal_tick <= !xtal_tick;
		end
	end
endmodule

// ==== sim/tb_top.sv ====
// register-level bench for the rtc power controller
// assumes brpc_far_side stands in for regulator, wake pin, battery and oscillator
`timescale 1ns/1ps
`include "brpc_regs.svh"
module tb_top;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	brpc_pkg::brpc_bus_s bus = '0;
	logic [31:0] rdata;
	logic xtal_tick, osc_tick, batt_low, wake_n, regulator_off_n, regulator_off_oe_n, irq, power_on;
	logic batt_cmd = 1'b0;
	logic wake_cmd = 1'b0;
	int fails = 0;
	int checked = 0;
	int cyc = 0;
	brpc_core dut (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata), .xtal_tick(xtal_tick),
		.osc_tick(osc_tick), .batt_low(batt_low), .wake_n(wake_n), .regulator_off_n(regulator_off_n),
		.regulator_off_oe_n(regulator_off_oe_n), .irq(irq));
	brpc_far_side far (.sys_clk(sys_clk), .resetn(resetn), .batt_cmd(batt_cmd), .wake_cmd(wake_cmd),
		.regulator_off_n(regulator_off_n), .regulator_off_oe_n(regulator_off_oe_n), .xtal_tick(xtal_tick),
		.osc_tick(osc_tick), .batt_low(batt_low), .wake_n(wake_n), .power_on(power_on));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic conclude();
		if (fails == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
		#1 chk(exp, rdata);
	endtask
	// hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 100000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		int i;
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		rc(`BRPC_OFF_CTL, 32'h80000000);
		rc(`BRPC_OFF_MATCH0, 32'hFFFFFFFF);
		rc(`BRPC_OFF_MATCH1, 32'hFFFFFFFF);
		rc(`BRPC_OFF_LOAD, 32'hFFFFFFFF);
		rc(`BRPC_OFF_TRIM, 32'h00007FFF);
		rc(`BRPC_OFF_RAW, 32'h0);
		wr(`BRPC_OFF_CTL, 32'h40);
		repeat (600) @(posedge sys_clk);
		rc(`BRPC_OFF_CTL, 32'h80000040);
		wr(`BRPC_OFF_CTL, 32'h44);
		rc(`BRPC_OFF_CTL, 32'h80000044);
		wr(`BRPC_OFF_TRIM, 32'h7FF0);
		rc(`BRPC_OFF_TRIM, 32'h00007FF0);
		for (i = 0; i < 64; i++) wr(`BRPC_OFF_MEM_LO + 12'(i * 4), 32'hA5000000 + 32'(i));
		for (i = 0; i < 64; i++) rc(`BRPC_OFF_MEM_LO + 12'(i * 4), 32'hA5000000 + 32'(i));
		wr(12'h028, 32'h12345678);
		rc(12'h028, 32'h0);
		wr(`BRPC_OFF_LOAD, 32'h10);
		repeat (2) @(posedge sys_clk);
		rc(`BRPC_OFF_COUNT, 32'h10);
		batt_cmd <= 1'b1;
		wr(`BRPC_OFF_CTL, 32'hFD);
		repeat (4) @(posedge sys_clk);
		#1 chk(32'h1, 32'(power_on));
		rc(`BRPC_OFF_RAW, 32'h4);
		batt_cmd <= 1'b0;
		wr(`BRPC_OFF_CTL, 32'h64);
		wr(`BRPC_OFF_CLEAR, 32'hF);
		rc(`BRPC_OFF_RAW, 32'h0);
		wr(`BRPC_OFF_MATCH0, 32'h11);
		wr(`BRPC_OFF_MASK, 32'h1);
		rc(`BRPC_OFF_MASKED, 32'h0);
		for (i = 0; i < 40000 && irq !== 1'b1; i++) @(posedge sys_clk);
		rc(`BRPC_OFF_COUNT, 32'h11);
		rc(`BRPC_OFF_MASKED, 32'h1);
		chk(32'h1, 32'(irq));
		wr(`BRPC_OFF_CLEAR, 32'h1);
		rc(`BRPC_OFF_RAW, 32'h0);
		chk(32'h0, 32'(irq));
		wr(`BRPC_OFF_CTL, 32'h7D);
		repeat (3) @(posedge sys_clk);
		#1 chk(32'h0, 32'(power_on));
		chk(32'h0, 32'(regulator_off_oe_n));
		batt_cmd <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rc(`BRPC_OFF_RAW, 32'h0);
		batt_cmd <= 1'b0;
		repeat (20) @(posedge sys_clk);
		#1 chk(32'h0, 32'(power_on));
		wake_cmd <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk(32'h1, 32'(power_on));
		rc(`BRPC_OFF_RAW, 32'h8);
		wake_cmd <= 1'b0;
		wr(`BRPC_OFF_CLEAR, 32'hF);
		wr(`BRPC_OFF_LOAD, 32'h20);
		wr(`BRPC_OFF_MATCH1, 32'h21);
		wr(`BRPC_OFF_CTL, 32'h67);
		repeat (3) @(posedge sys_clk);
		#1 chk(32'h0, 32'(power_on));
		for (i = 0; i < 40000 && power_on !== 1'b1; i++) @(posedge sys_clk);
		rc(`BRPC_OFF_COUNT, 32'h21);
		rc(`BRPC_OFF_RAW, 32'h2);
		rc(`BRPC_OFF_MASKED, 32'h0);
		chk(32'h0, 32'(irq));
		wr(`BRPC_OFF_CTL, 32'h0);
		rc(`BRPC_OFF_CTL, 32'h80000040);
		conclude();
	end
endmodule
